// *** core/epp_pkg.sv ***
// Package for the EEPROM serial programming port
// Notes on behaviour
// - The device enters programming mode when the clock pin has been high for the setup interval and the data pin then rises.
// - On mode entry the device bulk-erases the whole map to zero before taking any data.
// - One programming cycle carries 288 bits in a single serial stream, all stored internally.
// - Bits arrive 16 per word, least significant first, clocked by the clock pin and carried on the data pin.
// - After each word the device writes it internally for at least the word write time and the programmer pauses; the write stretches while the buffer is full.
// - When a word write completes the device drives acknowledge pulses, high for ack_high_time and low for ack_low_time.
// - Acknowledge pulses continue until the programmer drives the clock pin low, which ends that word's acknowledge.
// - Exactly one verify read-back is allowed, only right after a programming cycle; later attempts are refused.
// - During verify the programmer clocks the clock pin and the device shows the map bit by bit, least significant first.
// - A verify request not preceded by programming is rejected.
package epp_pkg;
  localparam int WORD_BITS = 16;
  localparam int WORD_COUNT = 18;
  localparam int MAP_BITS = 288;
  localparam int CLK_MHZ = 100;
  // Times in microseconds
  localparam int SETUP_TIME_US = 2000;
  localparam int ERASE_TIME_US = 4000;
  localparam int WRITE_TIME_US = 50000;
  localparam int ACK_HIGH_TIME_US = 800;
  localparam int ACK_LOW_TIME_US = 800;
  localparam int SETUP_CYCLES = SETUP_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int ACK_HIGH_CYCLES = ACK_HIGH_TIME_US * CLK_MHZ;
  localparam int ACK_LOW_CYCLES = ACK_LOW_TIME_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int BIT_IDX_W = 4;
  localparam int WORD_IDX_W = 5;
  localparam int MAP_IDX_W = 9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_SHIFT,
    ST_WRITE,
    ST_ACK,
    ST_ARMED,
    ST_VERIFY
  } epp_state_type;

  // Pin group for the data pin
  typedef struct packed {
    logic data_out;
    logic data_oe;
  } epp_pin_type;

  // Buffer entry: one word and its index
  typedef struct packed {
    logic [WORD_IDX_W-1:0] idx;
    logic [WORD_BITS-1:0] word;
  } epp_entry_type;
endpackage : epp_pkg

// *** core/epp_port.sv ***
// Serial programming and verify port of the configuration EEPROM
`timescale 1ns/1ps
module epp_port #(
  parameter int SETUP_CYC = epp_pkg::SETUP_CYCLES,
  parameter int ERASE_CYC = epp_pkg::ERASE_CYCLES,
  parameter int WRITE_CYC = epp_pkg::WRITE_CYCLES,
  parameter int ACK_HIGH_CYC = epp_pkg::ACK_HIGH_CYCLES,
  parameter int ACK_LOW_CYC = epp_pkg::ACK_LOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Programming pins
  input wire logic prog_clock_pin,
  input wire logic data_in,
  output epp_pkg::epp_pin_type data_pin,
  // Memory view
  output logic [epp_pkg::MAP_BITS-1:0] map_out,
  output logic prog_active,
  output logic map_written,
  output logic verify_used,
  // Stored-word stream
  output logic word_valid,
  input wire logic word_ready,
  output epp_pkg::epp_entry_type word_data
);
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdat_sync;
    logic sclk_d;
    epp_pkg::epp_state_type st;
    logic [epp_pkg::CNT_W-1:0] cnt;
    logic [epp_pkg::BIT_IDX_W-1:0] bit_idx;
    logic [epp_pkg::WORD_IDX_W-1:0] word_idx;
    logic [epp_pkg::MAP_IDX_W-1:0] rd_idx;
    logic [epp_pkg::WORD_BITS-1:0] shreg;
    logic [epp_pkg::MAP_BITS-1:0] mem;
    logic programmed;
    logic used;
    logic ack_level;
    epp_pkg::epp_pin_type pin;
    epp_pkg::epp_entry_type [BUF_DEPTH-1:0] buf_q;
    logic [1:0] buf_cnt;
  } epp_regs_type;

  epp_regs_type r_reg;
  epp_regs_type r_next;

  logic sclk;
  logic sdat;
  logic sclk_rise;
  logic sclk_fall;
  logic push;
  logic pop;
  epp_pkg::epp_entry_type push_entry;

  assign sclk = r_reg.sclk_sync[1];
  assign sdat = r_reg.sdat_sync[1];
  assign sclk_rise = sclk & ~r_reg.sclk_d;
  assign sclk_fall = ~sclk & r_reg.sclk_d;
  assign word_valid = (r_reg.buf_cnt != 2'h0);
  assign pop = word_valid & word_ready;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    push = 1'b0;
    push_entry = '{idx: r_reg.word_idx, word: r_reg.shreg};
    // Only the second stage is read downstream
    r_next.sclk_sync = {r_reg.sclk_sync[0], prog_clock_pin};
    r_next.sdat_sync = {r_reg.sdat_sync[0], data_in};
    r_next.sclk_d = sclk;
    case (r_reg.st)
      epp_pkg::ST_IDLE, epp_pkg::ST_ARMED: begin
        r_next.pin = '0;
        if (r_reg.st == epp_pkg::ST_ARMED && !r_reg.used && sclk_rise) begin
          // Tested first: the verify clock rises with data low, like an entry start.
          // Limitation: once armed, the next clock rise always starts the verify.
          r_next.st = epp_pkg::ST_VERIFY;
          r_next.used = 1'b1;
          r_next.rd_idx = '0;
          r_next.pin = '{data_out: r_reg.mem[0], data_oe: 1'b1};
          r_next.cnt = '0;
        end else if (sclk && !sdat) begin
          if (r_reg.cnt < epp_pkg::CNT_W'(SETUP_CYC)) begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end else if (sclk && sdat && r_reg.cnt >= epp_pkg::CNT_W'(SETUP_CYC)) begin
          r_next.st = epp_pkg::ST_ERASE;
          r_next.cnt = '0;
          r_next.mem = '0;
          r_next.programmed = 1'b0;
          r_next.used = 1'b0;
        end else begin
          r_next.cnt = '0;
        end
      end
      epp_pkg::ST_ERASE: begin
        // Bits clocked during the erase are dropped; the programmer must wait
        if (r_reg.cnt >= epp_pkg::CNT_W'(ERASE_CYC - 1)) begin
          r_next.st = epp_pkg::ST_SHIFT;
          r_next.cnt = '0;
          r_next.bit_idx = '0;
          r_next.word_idx = '0;
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      epp_pkg::ST_SHIFT: begin
        if (sclk_fall) begin
          r_next.shreg = {sdat, r_reg.shreg[epp_pkg::WORD_BITS-1:1]};
          r_next.bit_idx = r_reg.bit_idx + 1'b1;
          if (r_reg.bit_idx == epp_pkg::BIT_IDX_W'(epp_pkg::WORD_BITS - 1)) begin
            r_next.st = epp_pkg::ST_WRITE;
            r_next.cnt = '0;
          end
        end
      end
      epp_pkg::ST_WRITE: begin
        if (r_reg.cnt >= epp_pkg::CNT_W'(WRITE_CYC - 1) && r_reg.buf_cnt != 2'(BUF_DEPTH)) begin
          r_next.mem[r_reg.word_idx * epp_pkg::WORD_BITS +: epp_pkg::WORD_BITS] = r_reg.shreg;
          push = 1'b1;
          r_next.st = epp_pkg::ST_ACK;
          r_next.cnt = '0;
          r_next.ack_level = 1'b1;
          r_next.pin = '{data_out: 1'b1, data_oe: 1'b1};
        end else if (r_reg.buf_cnt != 2'(BUF_DEPTH)) begin
          // Write time stretches while the buffer is full
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      epp_pkg::ST_ACK: begin
        if (!sclk) begin
          r_next.pin = '0;
          r_next.bit_idx = '0;
          r_next.word_idx = r_reg.word_idx + 1'b1;
          if (r_reg.word_idx == epp_pkg::WORD_IDX_W'(epp_pkg::WORD_COUNT - 1)) begin
            r_next.st = epp_pkg::ST_ARMED;
            r_next.programmed = 1'b1;
            r_next.cnt = '0;
          end else begin
            r_next.st = epp_pkg::ST_SHIFT;
          end
        end else if (r_reg.ack_level && r_reg.cnt >= epp_pkg::CNT_W'(ACK_HIGH_CYC - 1)) begin
          r_next.ack_level = 1'b0;
          r_next.pin.data_out = 1'b0;
          r_next.cnt = '0;
        end else if (!r_reg.ack_level && r_reg.cnt >= epp_pkg::CNT_W'(ACK_LOW_CYC - 1)) begin
          r_next.ack_level = 1'b1;
          r_next.pin.data_out = 1'b1;
          r_next.cnt = '0;
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      epp_pkg::ST_VERIFY: begin
        if (sclk_rise) begin
          if (r_reg.rd_idx == epp_pkg::MAP_IDX_W'(epp_pkg::MAP_BITS - 1)) begin
            r_next.st = epp_pkg::ST_IDLE;
            r_next.pin = '0;
          end else begin
            r_next.rd_idx = r_reg.rd_idx + 1'b1;
            r_next.pin.data_out = r_reg.mem[r_reg.rd_idx + 1'b1];
          end
        end
      end
      default: begin
        r_next.st = epp_pkg::ST_IDLE;
      end
    endcase
    // Two-entry buffer of stored words
    if (pop) begin
      r_next.buf_q[0] = r_reg.buf_q[1];
    end
    if (push) begin
      r_next.buf_q[r_reg.buf_cnt - (pop ? 2'h1 : 2'h0)] = push_entry;
    end
    r_next.buf_cnt = r_reg.buf_cnt + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign data_pin = r_reg.pin;
  assign map_out = r_reg.mem;
  assign prog_active = (r_reg.st != epp_pkg::ST_IDLE) && (r_reg.st != epp_pkg::ST_ARMED);
  assign map_written = r_reg.programmed;
  assign verify_used = r_reg.used;
  assign word_data = r_reg.buf_q[0];

  ////////////////////////////////////////////////////////////////////////////
  property p_erase_clears;
    @(posedge clk) disable iff (rst)
      (clk_en && r_reg.st != epp_pkg::ST_ERASE && r_next.st == epp_pkg::ST_ERASE) |=> (r_reg.mem == '0);
  endproperty
  a_erase_clears: assert property (p_erase_clears) else $error("map not erased on entry");

  property p_entry_needs_setup;
    @(posedge clk) disable iff (rst)
      (clk_en && r_reg.st == epp_pkg::ST_IDLE && r_next.st == epp_pkg::ST_ERASE) |-> (r_reg.cnt >= SETUP_CYC && sclk);
  endproperty
  a_entry_needs_setup: assert property (p_entry_needs_setup) else $error("entry without setup");

  property p_ack_ends_low;
    @(posedge clk) disable iff (rst)
      (r_reg.st == epp_pkg::ST_ACK && !sclk && clk_en) |=> !data_pin.data_oe;
  endproperty
  a_ack_ends_low: assert property (p_ack_ends_low) else $error("ack not ended");

  property p_ack_starts_high;
    @(posedge clk) disable iff (rst)
      (r_reg.st == epp_pkg::ST_WRITE && r_next.st == epp_pkg::ST_ACK && clk_en) |=> (data_pin.data_out && data_pin.data_oe);
  endproperty
  a_ack_starts_high: assert property (p_ack_starts_high) else $error("ack pulse missing");

  property p_verify_once;
    @(posedge clk) disable iff (rst)
      (r_reg.st != epp_pkg::ST_VERIFY && r_next.st == epp_pkg::ST_VERIFY && clk_en) |-> (r_reg.programmed && !r_reg.used);
  endproperty
  a_verify_once: assert property (p_verify_once) else $error("verify not allowed");

  property p_verify_bit;
    @(posedge clk) disable iff (rst)
      (r_reg.st == epp_pkg::ST_VERIFY) |-> (data_pin.data_out == r_reg.mem[r_reg.rd_idx]);
  endproperty
  a_verify_bit: assert property (p_verify_bit) else $error("verify bit mismatch");

  property p_word_done;
    @(posedge clk) disable iff (rst)
      (r_reg.st == epp_pkg::ST_SHIFT && r_next.st == epp_pkg::ST_WRITE && clk_en)
        |-> (r_reg.bit_idx == epp_pkg::BIT_IDX_W'(epp_pkg::WORD_BITS - 1));
  endproperty
  a_word_done: assert property (p_word_done) else $error("word not 16 bits");

  property p_armed_after_last;
    @(posedge clk) disable iff (rst)
      (r_reg.st == epp_pkg::ST_ACK && r_next.st == epp_pkg::ST_ARMED && clk_en)
        |-> (r_reg.word_idx == epp_pkg::WORD_IDX_W'(epp_pkg::WORD_COUNT - 1));
  endproperty
  a_armed_after_last: assert property (p_armed_after_last) else $error("armed early");

  ////////////////////////////////////////////////////////////////////////////
  // Steps of the acknowledge handshake
  sequence s_write_end;
    clk_en && r_reg.st == epp_pkg::ST_WRITE && r_next.st == epp_pkg::ST_ACK;
  endsequence

  sequence s_ack_release;
    clk_en && r_reg.st == epp_pkg::ST_ACK && !sclk;
  endsequence

  sequence s_pin_released;
    !data_pin.data_oe && (r_reg.st == epp_pkg::ST_SHIFT || r_reg.st == epp_pkg::ST_ARMED);
  endsequence

  property p_write_to_stream;
    @(posedge clk) disable iff (rst)
      s_write_end |=> word_valid;
  endproperty
  a_write_to_stream: assert property (p_write_to_stream) else $error("stored word not offered");

  property p_release_to_next;
    @(posedge clk) disable iff (rst)
      s_ack_release |=> s_pin_released;
  endproperty
  a_release_to_next: assert property (p_release_to_next) else $error("pin kept after release");

  property p_ack_toggle_time;
    @(posedge clk) disable iff (rst)
      (clk_en && r_reg.st == epp_pkg::ST_ACK && sclk && r_next.ack_level != r_reg.ack_level)
        |-> (r_reg.cnt >= (r_reg.ack_level ? ACK_HIGH_CYC - 1 : ACK_LOW_CYC - 1));
  endproperty
  a_ack_toggle_time: assert property (p_ack_toggle_time) else $error("ack pulse too short");

  property p_shift_lsb_first;
    @(posedge clk) disable iff (rst)
      (clk_en && r_reg.st == epp_pkg::ST_SHIFT && sclk_fall)
        |=> (r_reg.shreg[epp_pkg::WORD_BITS-1] == $past(sdat));
  endproperty
  a_shift_lsb_first: assert property (p_shift_lsb_first) else $error("bit not shifted in");

  property p_pin_driven_when_owed;
    @(posedge clk) disable iff (rst)
      data_pin.data_oe |-> (r_reg.st == epp_pkg::ST_ACK || r_reg.st == epp_pkg::ST_VERIFY);
  endproperty
  a_pin_driven_when_owed: assert property (p_pin_driven_when_owed) else $error("pin driven idle");

  property p_verify_ends;
    @(posedge clk) disable iff (rst)
      (clk_en && r_reg.st == epp_pkg::ST_VERIFY && sclk_rise
        && r_reg.rd_idx == epp_pkg::MAP_IDX_W'(epp_pkg::MAP_BITS - 1))
        |=> (r_reg.st == epp_pkg::ST_IDLE && !data_pin.data_oe);
  endproperty
  a_verify_ends: assert property (p_verify_ends) else $error("verify overran");

  property p_entry_clears_flags;
    @(posedge clk) disable iff (rst)
      (clk_en && r_reg.st != epp_pkg::ST_ERASE && r_next.st == epp_pkg::ST_ERASE) |=> (!map_written && !verify_used);
  endproperty
  a_entry_clears_flags: assert property (p_entry_clears_flags) else $error("flags kept on entry");

  property p_buf_bounded;
    @(posedge clk) disable iff (rst)
      r_reg.buf_cnt <= 2'(BUF_DEPTH);
  endproperty
  a_buf_bounded: assert property (p_buf_bounded) else $error("buffer overflow");

  // Low enable must hold every bit of state
  property p_freeze;
    @(posedge clk) disable iff (rst)
      !clk_en |=> $stable(r_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : epp_port

// *** tb/epp_prog_model.sv ***
// Behavioural programmer driving the clock and data pins of the port
`timescale 1ns/1ps
module epp_prog_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic prog_clock_pin,
  output logic data_in,
  input wire epp_pkg::epp_pin_type data_pin
);
  logic drv_en;
  logic drv_val;
  // Weak pull-down on the wire; at rest nothing pulls it high
  assign data_in = data_pin.data_oe ? data_pin.data_out : (drv_en & drv_val);
  initial begin
    prog_clock_pin = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic enter(input int setup);
    prog_clock_pin = 1'b1;
    drv_en = 1'b1;
    drv_val = 1'b0;
    repeat (setup + 10) @(posedge clk);
    #1 drv_val = 1'b1;
    repeat (10) @(posedge clk);
    #1 drv_val = 1'b0;
  endtask : enter
  // Sends one word and measures the first ack pulse and the release
  task automatic send_word(input logic [15:0] w, input bit last, output int hl, output int ll, output int dl);
    int n;
    drv_en = 1'b1;
    for (int i = 0; i < 16; i++) begin
      drv_val = w[i];
      #62.5 prog_clock_pin = 1'b0;
      #62.5 prog_clock_pin = 1'b1;
    end
    drv_en = 1'b0;
    n = 0;
    hl = 0;
    ll = 0;
    dl = 0;
    // Pause for the internal write, bounded at 5000 cycles to allow for buffer stalls
    while (!(data_pin.data_oe && data_pin.data_out) && n < 5000) begin
      @(posedge clk) #1 n++;
    end
    while (data_pin.data_oe && data_pin.data_out && hl < 1000) begin
      @(posedge clk) #1 hl++;
    end
    while (data_pin.data_oe && !data_pin.data_out && ll < 1000) begin
      @(posedge clk) #1 ll++;
    end
    prog_clock_pin = 1'b0;
    while (data_pin.data_oe && dl < 1000) begin
      @(posedge clk) #1 dl++;
    end
    if (!last) begin
      #62.5 prog_clock_pin = 1'b1;
    end
  endtask : send_word
  task automatic read_bit(output logic [1:0] vb);
    prog_clock_pin = 1'b1;
    #62.5 vb = {data_pin.data_oe, data_pin.data_out};
    prog_clock_pin = 1'b0;
    #62.5;
  endtask : read_bit
endmodule : epp_prog_model

// *** tb/eeprom_serial_programming_port_tb.sv ***
// Self-checking bench of the EEPROM serial programming port
`timescale 1ns/1ps
module eeprom_serial_programming_port_tb;
  localparam int SU = 20;
  localparam int ER = 20;
  localparam int AH = 10;
  localparam int AL = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic word_ready = 1'b0;
  logic clk_en = 1'b1;
  logic prog_clock_pin;
  logic data_in;
  epp_pkg::epp_pin_type data_pin;
  logic [epp_pkg::MAP_BITS-1:0] map_out;
  logic [287:0] exp_map = '0;
  logic prog_active;
  logic map_written;
  logic verify_used;
  logic word_valid;
  epp_pkg::epp_entry_type word_data;
  epp_pkg::epp_entry_type exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'h6099;

  epp_port #(.SETUP_CYC(SU), .ERASE_CYC(ER), .WRITE_CYC(20), .ACK_HIGH_CYC(AH), .ACK_LOW_CYC(AL)) i_epp_port (
    .clk(clk), .rst(rst), .clk_en(clk_en), .prog_clock_pin(prog_clock_pin), .data_in(data_in),
    .data_pin(data_pin), .map_out(map_out), .prog_active(prog_active), .map_written(map_written),
    .verify_used(verify_used), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
  epp_prog_model i_epp_prog_model (.clk(clk), .prog_clock_pin(prog_clock_pin), .data_in(data_in),
    .data_pin(data_pin));

  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [287:0] seen, input logic [287:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check
  task automatic final_report();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////
  // Sink stalls three cycles in four, yet each word drains well before the next arrives
  always @(posedge clk) begin
    #1 word_ready = ($random(seed) & 3) == 0;
  end
  always @(posedge clk) begin
    if (!rst && word_valid === 1'b1 && word_ready) begin
      check(word_data, exp_q.size() != 0 ? exp_q.pop_front() : 21'h1fffff, "stored word");
    end
  end
  initial begin
    #500_000;
    num_errors++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] w;
    logic [1:0] vb;
    int hl;
    int ll;
    int dl;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      i_epp_prog_model.read_bit(vb);
      check(vb[1], 1'b0, "verify before programming");
    end
    check(verify_used, 1'b0, "verify flag");
    i_epp_prog_model.enter(SU);
    check(prog_active, 1'b1, "mode entry");
    repeat (ER + 10) @(posedge clk);
    for (int n = 0; n < 18; n++) begin
      w = $random(seed);
      exp_map[16*n +: 16] = w;
      exp_q.push_back({n[4:0], w});
      i_epp_prog_model.send_word(w, n == 17, hl, ll, dl);
      check(hl, AH, "ack high time");
      check(ll, AL, "ack low time");
      check(dl <= 5, 1'b1, "ack release");
    end
    check(map_written, 1'b1, "cycle complete");
    check(prog_active, 1'b0, "mode left");
    check(map_out, exp_map, "stored map");
    for (int i = 0; i < 288; i++) begin
      i_epp_prog_model.read_bit(vb);
      check(vb, {1'b1, exp_map[i]}, "verify bit");
    end
    i_epp_prog_model.read_bit(vb);
    check(verify_used, 1'b1, "verify used");
    for (int i = 0; i < 4; i++) begin
      i_epp_prog_model.read_bit(vb);
      check(vb[1], 1'b0, "second verify");
    end
    check(exp_q.size(), 0, "buffer drained");
    // Frozen by the clock enable, an entry must leave no trace
    @(posedge clk) #1 clk_en = 1'b0;
    i_epp_prog_model.enter(SU);
    check(prog_active, 1'b0, "frozen entry");
    check(map_out, exp_map, "frozen map");
    @(posedge clk) #1 clk_en = 1'b1;
    i_epp_prog_model.enter(SU);
    repeat (ER + 10) @(posedge clk);
    check(map_out, '0, "bulk erase");
    check(map_written, 1'b0, "re-entry clears");
    final_report();
  end
endmodule : eeprom_serial_programming_port_tb
